// File: src/psc_config_status.sv
`default_nettype none
// Operation
// R1 - No frames accepted until configuration done
// R2 - Host sets configuration done after setup
// R3 - Configuration done sticky until system reset
// R4 - Check last four octets as FCS
// R5 - Host clears MAC FCS append then
// R6 - Select alignment: frame starts first chunk
// R7 - Zero alignment: start word offset zero
// R8 - No alignment: frame starts anywhere
// R9 - Credit interrupt at threshold after zero
// R10 - Transmit fast forward before full buffer
// R11 - Receive fast forward before full buffer
// R12 - Timestamp enable and select read zero
// R13 - Writable control guard enable, reset zero
// R14 - Chunk payload size code, reset 64
// R15 - Guard error flag, write one clears
// R16 - Bad FCS flag, write one clears
// R17 - Transmit stamp capture bits read zero
// R18 - Upper and unused config bits zero
// R19 - Read-only field writes ignored cleanly
module psc_config_status
  import psc_pkg::*;
(
  input  wire logic                clock,             // Device clock, 40 MHz
  input  wire logic                rst,               // Asynchronous reset, active high
  input  wire logic                linkClock,         // Serial link clock
  input  wire logic                txnValid,          // Control transaction strobe, link domain
  input  wire logic                txnWrite,          // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]   txnAddr,           // Register address
  input  wire logic [DATA_W-1:0]   txnWdata,          // Write data
  output logic      [DATA_W-1:0]   txnRdata,          // Read data, link domain
  output logic                     txnDone,           // Transaction answered, link domain
  output logic                     txnBusy,           // Transaction in flight, link domain
  input  wire logic                chipSelectN,       // Chip select pin, active low
  input  wire logic                rxChunkStart,      // Receive chunk begins
  input  wire logic [CREDIT_W-1:0] txCreditCount,     // Transmit credits available
  input  wire logic                guardErrorEvent,   // Control transaction check failed
  input  wire logic                fcsBadEvent,       // Host FCS found invalid
  output logic                     frameAcceptEn,     // Frames may be taken
  output logic                     txFcsCheckEn,      // Validate host FCS
  output logic                     rxAlignOnSelect,   // Align to select
  output logic                     rxAlignZeroOffset, // Align to payload start
  output logic                     rxZeroOffset,      // Start word offset forced to zero
  output logic                     rxStartAllowed,    // A frame may start in this chunk
  output logic      [1:0]          txCreditIrqLevel,  // Threshold code
  output logic                     txCreditIrq,       // Credits reached threshold, pulse
  output logic                     txFastForwardEn,   // Transmit cut-through
  output logic                     rxFastForwardEn,   // Receive cut-through
  output logic                     ctrlGuardEn,       // Control data protection
  output logic      [2:0]          chunkPayloadSize,  // Payload size code
  output logic                     ctrlGuardError,    // Guard error flag
  output logic                     txFcsBadFlag       // Bad FCS flag
);

  // Link side: capture request, toggle across, wait for the answering toggle
  logic              reqToggle, next_reqToggle;
  logic              holdWrite, next_holdWrite;
  logic [ADDR_W-1:0] holdAddr, next_holdAddr;
  logic [DATA_W-1:0] holdWdata, next_holdWdata;
  logic [DATA_W-1:0] next_txnRdata;
  logic              next_txnDone, next_txnBusy;
  logic              ackSeenLink, next_ackSeenLink;
  logic              ackSync;
  logic              ackToggle;
  logic [DATA_W-1:0] coreRdata;

  psc_sync #(.WIDTH(1)) ackSyncer (
    .clock(linkClock),
    .rst  (rst),
    .din  (ackToggle),
    .dout (ackSync)
  );

  always_comb begin
    next_reqToggle   = reqToggle;
    next_holdWrite   = holdWrite;
    next_holdAddr    = holdAddr;
    next_holdWdata   = holdWdata;
    next_txnRdata    = txnRdata;
    next_txnDone     = 1'b0;
    next_txnBusy     = txnBusy;
    next_ackSeenLink = ackSync;
    if (txnBusy && (ackSync != ackSeenLink)) begin
      // Held core data is stable: the core loaded it on the same edge as the toggle
      next_txnRdata = coreRdata;
      next_txnDone  = 1'b1;
      next_txnBusy  = 1'b0;
    end else if (!txnBusy && txnValid) begin
      next_holdWrite = txnWrite;
      next_holdAddr  = txnAddr;
      next_holdWdata = txnWdata;
      next_reqToggle = ~reqToggle;
      next_txnBusy   = 1'b1;
    end
  end

  always_ff @(posedge linkClock or posedge rst) begin
    if (rst) begin
      reqToggle   <= 1'b0;
      holdWrite   <= 1'b0;
      holdAddr    <= '0;
      holdWdata   <= '0;
      txnRdata    <= '0;
      txnDone     <= 1'b0;
      txnBusy     <= 1'b0;
      ackSeenLink <= 1'b0;
    end else begin
      reqToggle   <= next_reqToggle;
      holdWrite   <= next_holdWrite;
      holdAddr    <= next_holdAddr;
      holdWdata   <= next_holdWdata;
      txnRdata    <= next_txnRdata;
      txnDone     <= next_txnDone;
      txnBusy     <= next_txnBusy;
      ackSeenLink <= next_ackSeenLink;
    end
  end

  // Core side
  logic reqSync, reqSeen, next_reqSeen, next_ackToggle;
  logic csSync, csPrev, next_csPrev;
  logic access, wrCfg, wrSts, rdCfg, rdSts;
  logic [DATA_W-1:0] next_coreRdata, cfgView, stsView;
  logic next_frameAcceptEn, next_txFcsCheckEn, next_rxAlignOnSelect, next_rxAlignZeroOffset;
  logic next_rxZeroOffset, next_rxStartAllowed, next_txCreditIrq, next_txFastForwardEn;
  logic next_rxFastForwardEn, next_ctrlGuardEn, next_ctrlGuardError, next_txFcsBadFlag;
  logic [1:0] next_txCreditIrqLevel;
  logic [2:0] next_chunkPayloadSize;
  logic creditArmed, next_creditArmed;
  logic selectPending, next_selectPending;

  psc_sync #(.WIDTH(2)) coreSyncer (
    .clock(clock),
    .rst  (rst),
    .din  ({reqToggle, chipSelectN}),
    .dout ({reqSync, csSync})
  );

  always_comb begin
    access = reqSync != reqSeen;
    wrCfg  = access && holdWrite && (holdAddr == ADDR_CONFIG);
    wrSts  = access && holdWrite && (holdAddr == ADDR_STATUS);
    rdCfg  = access && !holdWrite && (holdAddr == ADDR_CONFIG);
    rdSts  = access && !holdWrite && (holdAddr == ADDR_STATUS);
    // Unlisted bits stay zero, including the stamp bits
    cfgView = '0; // R12 R18
    cfgView[CFG_DONE_BIT]               = frameAcceptEn;
    cfgView[CFG_FCS_CHECK_BIT]          = txFcsCheckEn;
    cfgView[CFG_ALIGN_CS_BIT]           = rxAlignOnSelect;
    cfgView[CFG_ALIGN_ZERO_BIT]         = rxAlignZeroOffset;
    cfgView[CFG_LEVEL_HI:CFG_LEVEL_LO]  = txCreditIrqLevel;
    cfgView[CFG_TX_FAST_BIT]            = txFastForwardEn;
    cfgView[CFG_RX_FAST_BIT]            = rxFastForwardEn;
    cfgView[CFG_GUARD_EN_BIT]           = ctrlGuardEn;
    cfgView[CFG_CPS_HI:CFG_CPS_LO]      = chunkPayloadSize;
    stsView = '0; // R17
    stsView[STS_GUARD_ERR_BIT] = ctrlGuardError;
    stsView[STS_FCS_BAD_BIT]   = txFcsBadFlag;

    next_reqSeen   = reqSync;
    next_ackToggle = access ? ~ackToggle : ackToggle;
    next_coreRdata = coreRdata;
    if (rdCfg) next_coreRdata = cfgView;
    else if (rdSts) next_coreRdata = stsView;
    else if (access) next_coreRdata = '0;

    next_frameAcceptEn     = frameAcceptEn;
    next_txFcsCheckEn      = txFcsCheckEn;
    next_rxAlignOnSelect   = rxAlignOnSelect;
    next_rxAlignZeroOffset = rxAlignZeroOffset;
    next_txCreditIrqLevel  = txCreditIrqLevel;
    next_txFastForwardEn   = txFastForwardEn;
    next_rxFastForwardEn   = rxFastForwardEn;
    next_ctrlGuardEn       = ctrlGuardEn;
    next_chunkPayloadSize  = chunkPayloadSize;
    // Only writable fields are taken; read-only bits of the word are dropped
    if (wrCfg) begin // R19
      next_frameAcceptEn     = frameAcceptEn | holdWdata[CFG_DONE_BIT]; // R1 R3
      next_txFcsCheckEn      = holdWdata[CFG_FCS_CHECK_BIT]; // R4
      next_rxAlignOnSelect   = holdWdata[CFG_ALIGN_CS_BIT]; // R6
      next_rxAlignZeroOffset = holdWdata[CFG_ALIGN_ZERO_BIT]; // R7
      next_txCreditIrqLevel  = holdWdata[CFG_LEVEL_HI:CFG_LEVEL_LO]; // R9
      next_txFastForwardEn   = holdWdata[CFG_TX_FAST_BIT]; // R10
      next_rxFastForwardEn   = holdWdata[CFG_RX_FAST_BIT]; // R11
      next_ctrlGuardEn       = holdWdata[CFG_GUARD_EN_BIT]; // R13
      next_chunkPayloadSize  = holdWdata[CFG_CPS_HI:CFG_CPS_LO]; // R14
    end

    // Set wins over a write-one clear in the same cycle
    next_ctrlGuardError = (ctrlGuardError & ~(wrSts & holdWdata[STS_GUARD_ERR_BIT]))
                        | (guardErrorEvent & ctrlGuardEn); // R15
    next_txFcsBadFlag   = (txFcsBadFlag & ~(wrSts & holdWdata[STS_FCS_BAD_BIT]))
                        | (fcsBadEvent & txFcsCheckEn); // R16

    // Credit threshold arms once credits run dry
    next_txCreditIrq = 1'b0;
    next_creditArmed = creditArmed;
    if (txCreditCount == '0) begin
      next_creditArmed = 1'b1;
    end else if (creditArmed && txCreditCount >= psc_level_credits(txCreditIrqLevel)) begin
      next_txCreditIrq = 1'b1; // R9
      next_creditArmed = 1'b0;
    end

    // Chip select falling edge opens the window for the first chunk
    next_csPrev        = csSync;
    next_selectPending = selectPending;
    if (rxChunkStart) next_selectPending = 1'b0;
    if (csPrev && !csSync) next_selectPending = 1'b1;
    next_rxZeroOffset   = rxAlignOnSelect | rxAlignZeroOffset; // R6 R7
    next_rxStartAllowed = !rxAlignOnSelect || selectPending; // R6 R8
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqSeen           <= 1'b0;
      ackToggle         <= 1'b0;
      coreRdata         <= '0;
      frameAcceptEn     <= 1'b0;
      txFcsCheckEn      <= 1'b0;
      rxAlignOnSelect   <= 1'b0;
      rxAlignZeroOffset <= 1'b0;
      txCreditIrqLevel  <= LEVEL_RESET;
      txFastForwardEn   <= 1'b0;
      rxFastForwardEn   <= 1'b0;
      ctrlGuardEn       <= 1'b0;
      chunkPayloadSize  <= CPS_RESET;
      ctrlGuardError    <= 1'b0;
      txFcsBadFlag      <= 1'b0;
      txCreditIrq       <= 1'b0;
      creditArmed       <= 1'b0;
      csPrev            <= 1'b0;
      selectPending     <= 1'b0;
      rxZeroOffset      <= 1'b0;
      rxStartAllowed    <= 1'b1;
    end else begin
      reqSeen           <= next_reqSeen;
      ackToggle         <= next_ackToggle;
      coreRdata         <= next_coreRdata;
      frameAcceptEn     <= next_frameAcceptEn;
      txFcsCheckEn      <= next_txFcsCheckEn;
      rxAlignOnSelect   <= next_rxAlignOnSelect;
      rxAlignZeroOffset <= next_rxAlignZeroOffset;
      txCreditIrqLevel  <= next_txCreditIrqLevel;
      txFastForwardEn   <= next_txFastForwardEn;
      rxFastForwardEn   <= next_rxFastForwardEn;
      ctrlGuardEn       <= next_ctrlGuardEn;
      chunkPayloadSize  <= next_chunkPayloadSize;
      ctrlGuardError    <= next_ctrlGuardError;
      txFcsBadFlag      <= next_txFcsBadFlag;
      txCreditIrq       <= next_txCreditIrq;
      creditArmed       <= next_creditArmed;
      csPrev            <= next_csPrev;
      selectPending     <= next_selectPending;
      rxZeroOffset      <= next_rxZeroOffset;
      rxStartAllowed    <= next_rxStartAllowed;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_accept_gate_off: assert property (!frameAcceptEn && !wrCfg |=> !frameAcceptEn) // R1
    else $error("frames enabled without a configuration write");
  chk_done_stays_set: assert property (frameAcceptEn |=> frameAcceptEn) // R3
    else $error("configuration done cleared without reset");
  chk_done_set_write: assert property (wrCfg && holdWdata[CFG_DONE_BIT] |=> frameAcceptEn) // R1
    else $error("configuration done not set by write");
  chk_guard_flag_set: assert property (guardErrorEvent && ctrlGuardEn |=> ctrlGuardError) // R15
    else $error("guard error event lost");
  chk_guard_flag_gated: assert property
    (!ctrlGuardError && !(guardErrorEvent && ctrlGuardEn) |=> !ctrlGuardError) // R15
    else $error("guard error flag set without cause");
  chk_fcs_flag_clear: assert property
    (txFcsBadFlag && wrSts && holdWdata[STS_FCS_BAD_BIT] && !fcsBadEvent |=> !txFcsBadFlag) // R16
    else $error("bad FCS flag not cleared by write one");
  chk_fcs_set_wins: assert property
    (wrSts && holdWdata[STS_FCS_BAD_BIT] && fcsBadEvent && txFcsCheckEn |=> txFcsBadFlag) // R16
    else $error("bad FCS event lost to a write-one clear");
  // Stamp positions differ per register: bits 10:9 of the configuration word are live
  chk_stamp_reads_zero: assert property
    (rdCfg |=> coreRdata[CFG_STAMP_EN_BIT:CFG_STAMP_SEL_BIT] == 2'h0) // R12
    else $error("configuration stamp bits read nonzero");
  chk_status_stamps_zero: assert property
    (rdSts |=> coreRdata[STS_STAMP_C_BIT:STS_STAMP_B_BIT] == 2'h0) // R17
    else $error("status stamp bits read nonzero");
  chk_upper_reads_zero: assert property
    (rdCfg |=> coreRdata[DATA_W-1:CFG_DONE_BIT+1] == '0 && coreRdata[4:3] == 2'h0) // R18
    else $error("unused configuration bits read nonzero");
  chk_status_write_isolated: assert property (wrSts |=> $stable(chunkPayloadSize)
    && $stable(ctrlGuardEn) && $stable(txFastForwardEn)) // R19
    else $error("status write disturbed configuration");
  chk_credit_irq_level: assert property
    (txCreditIrq |-> $past(creditArmed) &&
     $past(txCreditCount) >= psc_level_credits($past(txCreditIrqLevel))) // R9
    else $error("credit interrupt below threshold");
  chk_zero_offset: assert property
    (rxAlignOnSelect || rxAlignZeroOffset |=> rxZeroOffset) // R6 R7
    else $error("start offset not forced to zero");
  chk_size_written: assert property
    (wrCfg |=> chunkPayloadSize == $past(holdWdata[CFG_CPS_HI:CFG_CPS_LO])) // R14
    else $error("payload size not taken from write");

  cov_config_done: cover property (!frameAcceptEn ##1 frameAcceptEn);
  cov_guard_error: cover property ($rose(ctrlGuardError));
  cov_credit_irq: cover property (txCreditIrq);
  cov_clear_race: cover property (wrSts && holdWdata[STS_FCS_BAD_BIT] && fcsBadEvent);

endmodule
`default_nettype wire

// File: src/psc_pkg.sv
`default_nettype none
package psc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register addresses in memory map zero
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0008;

  // Configuration register field positions
  localparam int CFG_DONE_BIT      = 15;
  localparam int CFG_FCS_CHECK_BIT = 14;
  localparam int CFG_ALIGN_CS_BIT  = 13;
  localparam int CFG_ALIGN_ZERO_BIT = 12;
  localparam int CFG_LEVEL_HI      = 11;
  localparam int CFG_LEVEL_LO      = 10;
  localparam int CFG_TX_FAST_BIT   = 9;
  localparam int CFG_RX_FAST_BIT   = 8;
  localparam int CFG_STAMP_EN_BIT  = 7;
  localparam int CFG_STAMP_SEL_BIT = 6;
  localparam int CFG_GUARD_EN_BIT  = 5;
  localparam int CFG_CPS_HI        = 2;
  localparam int CFG_CPS_LO        = 0;

  // Status register field positions
  localparam int STS_GUARD_ERR_BIT = 12;
  localparam int STS_FCS_BAD_BIT   = 11;
  localparam int STS_STAMP_C_BIT   = 10;
  localparam int STS_STAMP_B_BIT   = 9;

  // Reset values
  localparam logic [2:0] CPS_RESET   = 3'h6;
  localparam logic [1:0] LEVEL_RESET = 2'h0;

  // Credit threshold codes
  localparam logic [1:0] LEVEL_1  = 2'h0;
  localparam logic [1:0] LEVEL_4  = 2'h1;
  localparam logic [1:0] LEVEL_8  = 2'h2;
  localparam logic [1:0] LEVEL_16 = 2'h3;

  localparam int CREDIT_W = 8;

  function automatic logic [CREDIT_W-1:0] psc_level_credits(input logic [1:0] code);
    logic [CREDIT_W-1:0] credits;
    credits = 8'h01;
    case (code)
      LEVEL_1:  credits = 8'h01;
      LEVEL_4:  credits = 8'h04;
      LEVEL_8:  credits = 8'h08;
      LEVEL_16: credits = 8'h10;
      default:  credits = 8'h01;
    endcase
    return credits;
  endfunction

endpackage
`default_nettype wire

// File: src/psc_sync.sv
`default_nettype none
module psc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock, // Destination clock
  input  wire logic             rst,   // Asynchronous reset, active high
  input  wire logic [WIDTH-1:0] din,   // Signal from another domain
  output logic      [WIDTH-1:0] dout   // Synchronised copy
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule
`default_nettype wire

// File: bench/psc_host_model.sv
`default_nettype none
// Host side of the control link: gates its own link clock and holds chip select
// low only while a transaction is in flight.
module psc_host_model
  import psc_pkg::*;
(
  input  wire logic              rawLink,     // Free-running link oscillator
  output logic                   linkClock,   // Gated link clock to the device
  output logic                   chipSelectN, // Chip select, active low
  output logic                   txnValid,    // Request strobe
  output logic                   txnWrite,    // 1 write, 0 read
  output logic      [ADDR_W-1:0] txnAddr,     // Register address
  output logic      [DATA_W-1:0] txnWdata,    // Write data
  input  wire logic [DATA_W-1:0] txnRdata,    // Read data
  input  wire logic              txnDone      // Answer pulse
);
  timeunit 1ns;
  timeprecision 100ps;

  logic run;
  logic hang;

  // Gate changes only while the oscillator is low, so no runt pulses
  assign linkClock = rawLink & run;

  initial begin
    run = 1'h0;
    hang = 1'h0;
    chipSelectN = 1'h1;
    txnValid = 1'h0;
    txnWrite = 1'h0;
    txnAddr = '0;
    txnWdata = '0;
  end

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    int n;
    @(negedge rawLink);
    run = 1'h1;
    chipSelectN = 1'h0;
    repeat (2) @(negedge rawLink);
    txnValid = 1'h1;
    txnWrite = wr;
    txnAddr = addr;
    txnWdata = wd;
    @(negedge rawLink);
    // Released lines must not keep the old value, or a sloppy sample would pass
    txnValid = 1'h0;
    txnWrite = ~wr;
    txnAddr = ~addr;
    txnWdata = ~wd;
    n = 0;
    while (txnDone !== 1'h1 && n < 40) begin
      @(negedge rawLink);
      n++;
    end
    if (n >= 40) begin
      hang = 1'h1;
    end
    rd = txnRdata;
    @(negedge rawLink);
    run = 1'h0;
    chipSelectN = 1'h1;
  endtask
endmodule
`default_nettype wire

// File: bench/test_spi_protocol_config_status.sv
`default_nettype none
module test_spi_protocol_config_status
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 1'h0, rawLink = 1'h0, rst = 1'h1;
  logic linkClock, txnValid, txnWrite, txnDone, txnBusy, chipSelectN;
  logic [ADDR_W-1:0] txnAddr;
  logic [DATA_W-1:0] txnWdata, txnRdata, shadow, got, irqs, irqBase;
  logic macFcsAppend;
  logic rxChunkStart, guardErrorEvent, fcsBadEvent, frameAcceptEn, txFcsCheckEn;
  logic rxAlignOnSelect, rxAlignZeroOffset, rxZeroOffset, rxStartAllowed, txCreditIrq;
  logic txFastForwardEn, rxFastForwardEn, ctrlGuardEn, ctrlGuardError, txFcsBadFlag;
  logic [1:0] txCreditIrqLevel;
  logic [2:0] chunkPayloadSize;
  logic [CREDIT_W-1:0] txCreditCount;
  int errors = 0, compares = 0, junk;

  always #12.5 clock = ~clock;
  always #16 rawLink = ~rawLink;
  always @(posedge clock) begin
    if (rst) irqs <= '0;
    else if (txCreditIrq === 1'h1) irqs <= irqs + 32'h1;
  end

  psc_host_model i_host (.rawLink(rawLink), .linkClock(linkClock), .chipSelectN(chipSelectN),
    .txnValid(txnValid), .txnWrite(txnWrite), .txnAddr(txnAddr), .txnWdata(txnWdata),
    .txnRdata(txnRdata), .txnDone(txnDone));

  psc_config_status i_dut (.clock(clock), .rst(rst), .linkClock(linkClock),
    .txnValid(txnValid), .txnWrite(txnWrite), .txnAddr(txnAddr), .txnWdata(txnWdata),
    .txnRdata(txnRdata), .txnDone(txnDone), .txnBusy(txnBusy), .chipSelectN(chipSelectN),
    .rxChunkStart(rxChunkStart), .txCreditCount(txCreditCount),
    .guardErrorEvent(guardErrorEvent), .fcsBadEvent(fcsBadEvent),
    .frameAcceptEn(frameAcceptEn), .txFcsCheckEn(txFcsCheckEn),
    .rxAlignOnSelect(rxAlignOnSelect), .rxAlignZeroOffset(rxAlignZeroOffset),
    .rxZeroOffset(rxZeroOffset), .rxStartAllowed(rxStartAllowed),
    .txCreditIrqLevel(txCreditIrqLevel), .txCreditIrq(txCreditIrq),
    .txFastForwardEn(txFastForwardEn), .rxFastForwardEn(rxFastForwardEn),
    .ctrlGuardEn(ctrlGuardEn), .chunkPayloadSize(chunkPayloadSize),
    .ctrlGuardError(ctrlGuardError), .txFcsBadFlag(txFcsBadFlag));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Writable bits follow the data; the done bit can only be raised
  function automatic logic [31:0] nextCfg(input logic [31:0] old, input logic [31:0] d);
    return (d & 32'h0000_7F27) | ((old | d) & 32'h0000_8000);
  endfunction

  function automatic logic [31:0] levelCredits(input logic [1:0] code);
    return (code == 2'h0) ? 32'h1 : (code == 2'h1) ? 32'h4 : (code == 2'h2) ? 32'h8 : 32'h10;
  endfunction

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    i_host.xfer(wr, a, d, got);
    if (i_host.hang || txnBusy !== 1'h0) begin
      errors++;
      $display("ERROR at %0t: transaction not answered", $time);
    end
    if (wr && a == ADDR_CONFIG) begin
      shadow = nextCfg(shadow, d);
    end
  endtask

  task automatic readChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    access(1'h0, a, 32'h0);
    check(got, exp);
  endtask

  task automatic portsChk();
    repeat (3) @(negedge clock);
    check({16'h0, frameAcceptEn, txFcsCheckEn, rxAlignOnSelect, rxAlignZeroOffset,
      txCreditIrqLevel, txFastForwardEn, rxFastForwardEn, 2'h0, ctrlGuardEn, 2'h0,
      chunkPayloadSize}, shadow);
    check({31'h0, rxZeroOffset}, {31'h0, shadow[13] | shadow[12]});
  endtask

  task automatic pulseEvents();
    @(negedge clock);
    guardErrorEvent = 1'h1;
    fcsBadEvent = 1'h1;
    @(negedge clock);
    guardErrorEvent = 1'h0;
    fcsBadEvent = 1'h0;
    repeat (2) @(negedge clock);
  endtask

  initial begin
    #500000;
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    rxChunkStart = 1'h0;
    txCreditCount = 8'h20;
    guardErrorEvent = 1'h0;
    fcsBadEvent = 1'h0;
    shadow = 32'h0000_0006;
    macFcsAppend = 1'h1;
    junk = $urandom(32'h379D);
    repeat (5) @(negedge clock);
    rst = 1'h0;
    portsChk();
    check({31'h0, rxStartAllowed}, 32'h1);
    readChk(ADDR_CONFIG, 32'h0000_0006);
    readChk(ADDR_STATUS, 32'h0);
    $display("test reset done");

    access(1'h1, ADDR_CONFIG, 32'h0000_2006);
    pulseEvents();
    @(negedge clock) rxChunkStart = 1'h1;
    @(negedge clock) rxChunkStart = 1'h0;
    repeat (3) @(negedge clock);
    check({31'h0, rxStartAllowed}, 32'h0);
    readChk(ADDR_STATUS, 32'h0);
    repeat (4) @(negedge clock);
    check({31'h0, rxStartAllowed}, 32'h1);
    access(1'h1, ADDR_CONFIG, 32'h0000_1006);
    portsChk();
    $display("test alignment done");

    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      d[2:0] = 3'(3 + $urandom_range(3));
      if (i < 2) d[15] = 1'h0;
      if (i == 8) d = 32'hFFFF_7FFB;
      access(1'h1, ADDR_CONFIG, d);
      readChk(ADDR_CONFIG, shadow);
      portsChk();
    end
    readChk(16'h000C, 32'h0);
    access(1'h1, 16'h000C, 32'hFFFF_FFFF);
    readChk(ADDR_CONFIG, shadow);
    $display("test config done");

    // The MAC must stop appending its own FCS before host FCS checking is enabled
    macFcsAppend = 1'h0;
    access(1'h1, ADDR_CONFIG, 32'h0000_C026);
    pulseEvents();
    readChk(ADDR_STATUS, 32'h0000_1800);
    check({30'h0, ctrlGuardError, txFcsBadFlag}, 32'h3);
    access(1'h1, ADDR_STATUS, 32'hFFFF_E7FF);
    readChk(ADDR_STATUS, 32'h0000_1800);
    readChk(ADDR_CONFIG, shadow);
    access(1'h1, ADDR_STATUS, 32'h0000_1000);
    readChk(ADDR_STATUS, 32'h0000_0800);
    // Event held across the write-one clear: the set must win
    @(negedge clock) fcsBadEvent = 1'h1;
    access(1'h1, ADDR_STATUS, 32'h0000_0800);
    @(negedge clock) fcsBadEvent = 1'h0;
    readChk(ADDR_STATUS, 32'h0000_0800);
    access(1'h1, ADDR_STATUS, 32'h0000_0800);
    readChk(ADDR_STATUS, 32'h0);
    $display("test status done");

    for (int c = 0; c < 4; c++) begin
      access(1'h1, ADDR_CONFIG, (shadow & 32'hFFFF_F3FF) | (32'(c) << 10));
      @(negedge clock) txCreditCount = 8'h00;
      repeat (4) @(negedge clock);
      irqBase = irqs;
      txCreditCount = 8'(levelCredits(2'(c)) - 32'h1);
      repeat (10) @(negedge clock);
      check(irqs - irqBase, 32'h0);
      txCreditCount = 8'(levelCredits(2'(c)) + 32'(c));
      repeat (10) @(negedge clock);
      check(irqs - irqBase, 32'h1);
    end
    $display("test credit done");
    wrap_up();
  end
endmodule
`default_nettype wire
